// >>> common/wait_ctrl_defines.vh
// Purpose: offsets, field positions, reset values and codes of the
//          external area wait-state register bank
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes:   included by bare name from axil_reg_port and ext_area_wait_state_control
`ifndef WAIT_CTRL_DEFINES_VH
`define WAIT_CTRL_DEFINES_VH

// register byte offsets
`define OFS_WAIT_7_6        8'h00
`define OFS_WAIT_5_4        8'h04
`define OFS_ACCESS_STATE    8'h08
`define OFS_ACCESS_STATUS   8'h0C

// wait field positions (lsb of each three-bit count)
`define AREA7_WAIT_LSB      12
`define AREA6_WAIT_LSB      8
`define AREA5_WAIT_LSB      4
`define AREA4_WAIT_LSB      0

// writable bit masks, reserved bits excluded
`define WAIT_7_6_MASK       32'h0000_7700
`define WAIT_5_4_MASK       32'h0000_0077
`define ACCESS_STATE_MASK   32'h0000_00F0

// reset values
`define WAIT_7_6_RESET      32'h0000_7700
`define WAIT_5_4_RESET      32'h0000_0077
`define ACCESS_STATE_RESET  32'h0000_00F0

// three-state select bits sit at area number in the access state register
`define AREA_SEL_LSB        4

// status register layout
`define STAT_BUSY_BIT       0
`define STAT_LOST_BIT       1
`define STAT_AREA_LSB       4
`define STAT_WAIT_LSB       8
`define STAT_THREE_BIT      11

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// >>> src/axil_reg_port.v
// Purpose: AXI4-Lite slave front end turning bus transfers into strobes
// Assumes: one write and one read outstanding at most
// Notes:   address and data of a write may arrive in either order
`timescale 1ns/1ps
module axil_reg_port (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address and data
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // register side
  output wire        reg_wr,
  output wire [7:0]  reg_waddr,
  output wire [31:0] reg_wdata,
  output wire [3:0]  reg_wstrb,
  input  wire        reg_wr_err,
  output wire [7:0]  reg_raddr,
  output wire        reg_rd,
  input  wire [31:0] reg_rd_data,
  input  wire        reg_rd_err
);
`include "wait_ctrl_defines.vh"

  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;

  // write fires once both halves are held and no response is pending
  assign reg_wr    = aw_held_reg & w_held_reg & ~bvalid;
  assign reg_waddr = waddr_reg;
  assign reg_wdata = wdata_reg;
  assign reg_wstrb = wstrb_reg;
  assign reg_raddr = araddr;
  assign reg_rd    = arvalid & arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg   <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      // ready drops the cycle after a take so each item is taken once
      awready <= ~aw_held_reg & ~(awvalid & awready) & ~reg_wr;
      wready  <= ~w_held_reg & ~(wvalid & wready) & ~reg_wr;
      if (reg_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= reg_wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (reg_rd) begin
        rvalid <= 1'b1;
        rdata  <= reg_rd_data;
        rresp  <= reg_rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> src/ext_access_timer.v
// Purpose: times one external access in states T1, T2, waits and T3
// Assumes: start is only honoured while idle
// Notes:   strobe stays high from T1 through the final state
`timescale 1ns/1ps
module ext_access_timer (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // access request
  input  wire       start,
  input  wire       three_state,
  input  wire [2:0] wait_cnt,
  // access progress
  output reg        strobe_reg,
  output reg        done_reg,
  output reg        busy_reg
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_T1   = 3'h1;
  localparam [2:0] ST_T2   = 3'h2;
  localparam [2:0] ST_TW   = 3'h3;
  localparam [2:0] ST_T3   = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [2:0] left_reg;
  reg [2:0] left_next;
  reg       three_reg;

  always @* begin
    state_next = state_reg;
    left_next  = left_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_T1;
          left_next  = wait_cnt;
        end
      end
      ST_T1: state_next = ST_T2;
      ST_T2: begin
        // two-state access ends here with no waits
        if (!three_reg)
          state_next = ST_IDLE;
        else if (left_reg != 3'h0)
          state_next = ST_TW;
        else
          state_next = ST_T3;
      end
      ST_TW: begin
        // one bus clock per programmed wait
        left_next = left_reg - 3'h1;
        if (left_reg == 3'h1)
          state_next = ST_T3;
      end
      ST_T3: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= ST_IDLE;
      left_reg   <= 3'h0;
      three_reg  <= 1'b0;
      strobe_reg <= 1'b0;
      done_reg   <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg  <= left_next;
      if (state_reg == ST_IDLE && start)
        three_reg <= three_state;
      strobe_reg <= (state_next != ST_IDLE);
      busy_reg   <= (state_next != ST_IDLE);
      done_reg   <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
    end
  end

endmodule

// >>> src/ext_area_wait_state_control.v
// Purpose: program-wait settings for external areas 7 to 4 and the
//          access timing that applies them
// Assumes: AXI4-Lite register access, access requests from same clock
// Notes:   wait settings are sampled when an access starts
`timescale 1ns/1ps
module ext_area_wait_state_control (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // external access request from the bus controller
  input  wire        acc_req,
  input  wire [1:0]  acc_area,
  // external access timing
  output wire        acc_strobe,
  output wire        acc_done,
  output wire        acc_busy
);
`include "wait_ctrl_defines.vh"

////////////////////////////////////////////////////////////////////////////
// register bus front end

  wire        reg_wr;
  wire [7:0]  reg_waddr;
  wire [31:0] reg_wdata;
  wire [3:0]  reg_wstrb;
  reg         reg_wr_err;
  wire [7:0]  reg_raddr;
  wire        reg_rd;
  reg  [31:0] reg_rd_data;
  reg         reg_rd_err;

  axil_reg_port u_port (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .awaddr      (s_axi_awaddr),
    .awvalid     (s_axi_awvalid),
    .awready     (s_axi_awready),
    .wdata       (s_axi_wdata),
    .wstrb       (s_axi_wstrb),
    .wvalid      (s_axi_wvalid),
    .wready      (s_axi_wready),
    .bresp       (s_axi_bresp),
    .bvalid      (s_axi_bvalid),
    .bready      (s_axi_bready),
    .araddr      (s_axi_araddr),
    .arvalid     (s_axi_arvalid),
    .arready     (s_axi_arready),
    .rdata       (s_axi_rdata),
    .rresp       (s_axi_rresp),
    .rvalid      (s_axi_rvalid),
    .rready      (s_axi_rready),
    .reg_wr      (reg_wr),
    .reg_waddr   (reg_waddr),
    .reg_wdata   (reg_wdata),
    .reg_wstrb   (reg_wstrb),
    .reg_wr_err  (reg_wr_err),
    .reg_raddr   (reg_raddr),
    .reg_rd      (reg_rd),
    .reg_rd_data (reg_rd_data),
    .reg_rd_err  (reg_rd_err)
  );

////////////////////////////////////////////////////////////////////////////
// helpers

  // expand byte strobes to a bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // merge a write into a register, touching writable enabled bits only
  function [31:0] merge_bits;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] en_mask;
    begin
      merge_bits = (old_val & ~en_mask) | (new_val & en_mask);
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `OFS_WAIT_7_6) || (addr == `OFS_WAIT_5_4) ||
                  (addr == `OFS_ACCESS_STATE) ||
                  (addr == `OFS_ACCESS_STATUS);
    end
  endfunction

  // status word: busy, lost request and the last access taken;
  // built in one place so the field layout has a single owner
  function [31:0] status_word;
    input       busy;
    input       lost;
    input [1:0] area;
    input [2:0] wt;
    input       three;
    begin
      status_word                      = 32'h0000_0000;
      status_word[`STAT_BUSY_BIT]      = busy;
      status_word[`STAT_LOST_BIT]      = lost;
      status_word[`STAT_AREA_LSB +: 2] = area;
      status_word[`STAT_WAIT_LSB +: 3] = wt;
      status_word[`STAT_THREE_BIT]     = three;
    end
  endfunction

////////////////////////////////////////////////////////////////////////////
// configuration registers

  reg  [31:0] wait_ctrl_areas_7_6;
  reg  [31:0] wait_ctrl_areas_5_4;
  reg  [31:0] access_state_ctrl_reg;
  reg         req_lost_reg;
  wire [31:0] wr_mask;
  wire        wr_wait_7_6;
  wire        wr_wait_5_4;
  wire        wr_access_state;

  assign wr_mask = strb_mask(reg_wstrb);

  // one strobe per register keeps the update process flat
  assign wr_wait_7_6     = reg_wr && (reg_waddr == `OFS_WAIT_7_6);
  assign wr_wait_5_4     = reg_wr && (reg_waddr == `OFS_WAIT_5_4);
  assign wr_access_state = reg_wr && (reg_waddr == `OFS_ACCESS_STATE);

  always @* begin
    reg_wr_err = ~is_mapped(reg_waddr);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      // all wait fields start at seven waits
      wait_ctrl_areas_7_6   <= `WAIT_7_6_RESET;
      wait_ctrl_areas_5_4   <= `WAIT_5_4_RESET;
      access_state_ctrl_reg <= `ACCESS_STATE_RESET;
    end else begin
      // reserved positions are masked out of every write
      if (wr_wait_7_6)
        wait_ctrl_areas_7_6 <= merge_bits(wait_ctrl_areas_7_6, reg_wdata,
                                          wr_mask & `WAIT_7_6_MASK);
      if (wr_wait_5_4)
        wait_ctrl_areas_5_4 <= merge_bits(wait_ctrl_areas_5_4, reg_wdata,
                                          wr_mask & `WAIT_5_4_MASK);
      if (wr_access_state)
        access_state_ctrl_reg <= merge_bits(access_state_ctrl_reg,
                                            reg_wdata,
                                            wr_mask & `ACCESS_STATE_MASK);
    end
  end

////////////////////////////////////////////////////////////////////////////
// per-area settings

  // codes on acc_area
  localparam [1:0] AREA4_CODE = 2'h0;
  localparam [1:0] AREA5_CODE = 2'h1;
  localparam [1:0] AREA6_CODE = 2'h2;
  localparam [1:0] AREA7_CODE = 2'h3;

  // separate count per area, each from its own field
  wire [2:0] area7_wait;
  wire [2:0] area6_wait;
  wire [2:0] area5_wait;
  wire [2:0] area4_wait;

  assign area7_wait = wait_ctrl_areas_7_6[`AREA7_WAIT_LSB +: 3];
  assign area6_wait = wait_ctrl_areas_7_6[`AREA6_WAIT_LSB +: 3];
  assign area5_wait = wait_ctrl_areas_5_4[`AREA5_WAIT_LSB +: 3];
  assign area4_wait = wait_ctrl_areas_5_4[`AREA4_WAIT_LSB +: 3];

  wire [3:0] area_three_state_sel = access_state_ctrl_reg[`AREA_SEL_LSB +: 4];

  reg  [2:0] sel_wait;
  reg        sel_three;
  reg  [2:0] eff_wait;

  always @* begin
    case (acc_area)
      AREA7_CODE: sel_wait = area7_wait;
      AREA6_CODE: sel_wait = area6_wait;
      AREA5_CODE: sel_wait = area5_wait;
      AREA4_CODE: sel_wait = area4_wait;
      default:    sel_wait = area4_wait;
    endcase
    sel_three = area_three_state_sel[acc_area];
    // count only counts in three-state mode
    // field value is used directly as the number of waits
    eff_wait = sel_three ? sel_wait : 3'h0;
  end

////////////////////////////////////////////////////////////////////////////
// access timing

  wire       start;
  wire       busy_int;
  reg  [1:0] last_area_reg;
  reg  [2:0] last_wait_reg;
  reg        last_three_reg;
  wire       clear_lost;

  // a request is taken only while idle; settings are latched at start,
  // so a register write during an access only shapes the next one
  assign start = acc_req & ~busy_int;

  // the access length below is what the external device must meet
  ext_access_timer u_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (start),
    .three_state (sel_three),
    .wait_cnt    (eff_wait),
    .strobe_reg  (acc_strobe),
    .done_reg    (acc_done),
    .busy_reg    (busy_int)
  );

  assign acc_busy = busy_int;

  // write one to the lost bit clears it
  assign clear_lost = reg_wr && (reg_waddr == `OFS_ACCESS_STATUS) &&
                      reg_wstrb[0] && reg_wdata[`STAT_LOST_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      last_area_reg  <= 2'h0;
      last_wait_reg  <= 3'h0;
      last_three_reg <= 1'b0;
      req_lost_reg   <= 1'b0;
    end else begin
      if (start) begin
        last_area_reg  <= acc_area;
        last_wait_reg  <= eff_wait;
        last_three_reg <= sel_three;
      end
      // a request refused while busy is flagged; set wins over clear
      if (acc_req && busy_int)
        req_lost_reg <= 1'b1;
      else if (clear_lost)
        req_lost_reg <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////
// read decode

  always @* begin
    reg_rd_data = 32'h0000_0000;
    reg_rd_err  = 1'b0;
    case (reg_raddr)
      `OFS_WAIT_7_6:
        reg_rd_data = wait_ctrl_areas_7_6 & `WAIT_7_6_MASK;
      `OFS_WAIT_5_4:
        reg_rd_data = wait_ctrl_areas_5_4 & `WAIT_5_4_MASK;
      `OFS_ACCESS_STATE:
        reg_rd_data = access_state_ctrl_reg & `ACCESS_STATE_MASK;
      `OFS_ACCESS_STATUS:
        reg_rd_data = status_word(busy_int, req_lost_reg, last_area_reg,
                                  last_wait_reg, last_three_reg);
      // unmapped offsets read zero and answer with an error
      default:
        reg_rd_err = 1'b1;
    endcase
  end

endmodule

// >>> tb/ext_device_model.sv
// Purpose: external device that needs a fixed number of strobe cycles
// Assumes: strobe framed by the access timer
// Notes:   xfer_ok holds the verdict of the last access until the next
`timescale 1ns/1ps
module ext_device_model (
  // clock
  input wire       aclk,
  // access strobe
  input wire       acc_strobe,
  input wire [3:0] latency,
  // verdict
  output reg       xfer_ok
);
  reg [3:0] cnt_reg;
  initial begin
    cnt_reg = 4'h0;
    xfer_ok = 1'b0;
  end
  // device completes only once latency strobe cycles have passed
  always @(posedge aclk) begin
    if (acc_strobe) begin
      cnt_reg <= cnt_reg + 4'h1;
      xfer_ok <= (cnt_reg + 4'h1 >= latency);
    end else begin
      cnt_reg <= 4'h0;
    end
  end
endmodule

// >>> tb/testbench.sv
// Purpose: register and access-length tests of the area wait-state bank
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes:   access length is counted in strobe-high cycles
`timescale 1ns/1ps
module testbench;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb;
  reg  [3:0]  lat;
  reg         acc_req;
  reg  [1:0]  acc_area;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        acc_strobe, acc_done, acc_busy, xfer_ok;
  integer     bad_count, n_checks, cyc, i;
  reg  [2:0]  v;
  ext_area_wait_state_control u_ext_area_wait_state_control (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .acc_req(acc_req),
    .acc_area(acc_area), .acc_strobe(acc_strobe), .acc_done(acc_done),
    .acc_busy(acc_busy));
  ext_device_model u_ext_device_model (
    .aclk(aclk), .acc_strobe(acc_strobe), .latency(lat),
    .xfer_ok(xfer_ok));
  ////////////////////////////////////////////////////////////////////////
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task chk32(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk2(input [1:0] got, input [1:0] exp);
    begin
      chk32({30'h0, got}, {30'h0, exp});
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!done) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          done = 1'b1;
          bready <= 1'b0;
          chk2(bresp, er);
        end
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!done) begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1) begin
          done = 1'b1;
          rready <= 1'b0;
          chk32(rdata, exp);
          chk2(rresp, er);
        end
      end
    end
  endtask
  // counts strobe-high cycles of one access and compares the total
  task acc(input [1:0] a, input [31:0] exp_len);
    integer c;
    begin
      c = 0;
      acc_req <= 1'b1; acc_area <= a;
      lat     <= exp_len[3:0];
      @(posedge aclk);
      acc_req <= 1'b0;
      #1;
      while (acc_done !== 1'b1) begin
        if (acc_strobe === 1'b1) c = c + 1;
        @(posedge aclk);
        #1;
      end
      chk32(c, exp_len);
      chk32({31'h0, xfer_ok}, 32'h1);
      @(posedge aclk);
    end
  endtask
  task end_of_test;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00;
    araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; acc_req = 1'b0;
    acc_area = 2'h0; bad_count = 0; n_checks = 0; cyc = 0;
    lat = 4'h2;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    acc(2'h0, 32'd10);
    rd(8'h00, 32'h0000_7700, 2'h0);
    rd(8'h04, 32'h0000_0077, 2'h0);
    rd(8'h08, 32'h0000_00F0, 2'h0);
    wr(8'h00, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(8'h00, 32'h0000_7700, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(8'h04, 32'h0000_0077, 2'h0);
    wr(8'h00, 32'h0, 4'h1, 2'h0); // bytes not strobed stay put
    rd(8'h00, 32'h0000_7700, 2'h0);
    for (i = 0; i < 8; i = i + 1) begin
      v = i[2:0];
      wr(8'h00, {17'h0, v, 1'b0, ~v, 8'h00}, 4'hF, 2'h0);
      wr(8'h04, {25'h0, v ^ 3'h5, 1'b0, v ^ 3'h2}, 4'hF, 2'h0);
      rd(8'h00, {17'h0, v, 1'b0, ~v, 8'h00}, 2'h0);
      rd(8'h04, {25'h0, v ^ 3'h5, 1'b0, v ^ 3'h2}, 2'h0);
      acc(2'h3, 32'd3 + v);
      acc(2'h2, 32'd3 + {29'h0, ~v});
      acc(2'h1, 32'd3 + {29'h0, v ^ 3'h5});
      acc(2'h0, 32'd3 + {29'h0, v ^ 3'h2});
    end
    // waits now 7, 0, 2, 5 for areas 7 to 4
    wr(8'h08, 32'h0000_0050, 4'hF, 2'h0);
    rd(8'h08, 32'h0000_0050, 2'h0);
    acc(2'h3, 32'd2);
    acc(2'h2, 32'd3);
    acc(2'h1, 32'd2);
    acc(2'h0, 32'd8);
    rd(8'h0C, 32'h0000_0D00, 2'h0); // last access: area 4, five waits
    // a request held into the busy phase is refused and flagged
    acc_area <= 2'h1;
    acc_req  <= 1'b1;
    repeat (2) @(posedge aclk);
    acc_req <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h0C, 32'h0000_0012, 2'h0); // lost flag, area 5, two states
    wr(8'h0C, 32'h0000_0002, 4'h1, 2'h0); // writing one clears lost
    rd(8'h0C, 32'h0000_0010, 2'h0); // lost flag gone
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(8'h04, 32'h0000_0025, 2'h0);
    end_of_test;
  end
endmodule

// >>> tb/wait_ctrl_props.sv
// Purpose: port-level checks of the area wait-state bank and access timer
// Assumes: single clock, synchronous active-low reset
// Notes:   longest access is 3 states plus 7 waits
`timescale 1ns/1ps
module wait_ctrl_props (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // access port
  input wire        acc_req,
  input wire        acc_strobe,
  input wire        acc_done,
  input wire        acc_busy
);
  reg [7:0] rd_addr_reg;
  reg [3:0] slen_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_reg <= s_axi_araddr;
    slen_reg <= acc_strobe ? slen_reg + 4'h1 : 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  a_busy_strobe_eq: assert property (acc_busy == acc_strobe)
    else $error("busy differs from strobe");
  a_start_strobe: assert property (
    acc_req && !acc_busy |=> acc_strobe) else $error("access not started");
  a_strobe_min_two: assert property (
    $rose(acc_strobe) |=> acc_strobe) else $error("access under two states");
  a_strobe_max_len: assert property (slen_reg <= 4'hA)
    else $error("access longer than ten states");
  a_done_single: assert property (acc_done |=> !acc_done)
    else $error("done wider than one cycle");
  a_done_after_end: assert property (
    acc_done |-> !acc_strobe && $past(acc_strobe))
    else $error("done without a finished access");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_reserved_zero: assert property (
    s_axi_rvalid && rd_addr_reg < 8'h08 |->
    (s_axi_rdata & 32'hFFFF_8888) == 32'h0000_0000)
    else $error("reserved bit read as one");
  a_bvalid_clear: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind ext_area_wait_state_control wait_ctrl_props u_wait_ctrl_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .acc_req(acc_req), .acc_strobe(acc_strobe), .acc_done(acc_done),
  .acc_busy(acc_busy));
